// *** src/adc_result_and_reference_select.v ***
// apb register file, selection locking and result capture of the converter
`timescale 1ns/1ps
`default_nettype none
`include "adc_sel_consts.vh"

module adc_result_and_reference_select #(
  parameter ADDR_W = 8
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire conv_done,
  input wire [9:0] conv_se_code,
  input wire [10:0] conv_diff_code,
  input wire irq_ack,
  output wire conv_start,
  output wire conv_busy,
  output wire adc_enable,
  output wire [5:0] active_channel,
  output wire diff_mode,
  output wire gain_20x,
  output wire bipolar_mode,
  output wire temp_sensor_en,
  output wire ref_vcc_en,
  output wire ref_ext_en,
  output wire ref_int_en,
  output wire ref_pin_drive,
  output wire irq
);

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire setup_ph;
  wire access_ph;
  wire wr_acc;
  wire rd_acc;
  wire lane0;
  wire [3:0] idx;
  wire addr_hit;
  wire upper_zero;

  function is_reg;
    input [3:0] i;
    begin
      is_reg = (i == `IDX_CTRL_B) || (i == `IDX_RESULT_LOW) ||
               (i == `IDX_RESULT_HIGH) || (i == `IDX_CTRL_A) ||
               (i == `IDX_INPUT_SELECT) || (i == `IDX_IRQ_STATUS) ||
               (i == `IDX_IRQ_MASK);
    end
  endfunction

  assign idx = paddr[5:2];
  assign upper_zero = (paddr[ADDR_W-1:6] == {(ADDR_W-6){1'b0}}) && (paddr[1:0] == 2'b00);
  assign addr_hit = upper_zero && is_reg(idx);
  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;
  assign wr_acc = access_ph & pwrite & addr_hit;
  assign rd_acc = access_ph & ~pwrite & addr_hit;
  // registers are one byte wide, so only the lowest lane matters
  assign lane0 = pstrb[0];
  // zero wait states keeps software timing simple
  assign pready = 1'b1;
  // unmapped or misaligned: refused, the write is dropped and reads give zero
  assign pslverr = access_ph & ~addr_hit;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [7:0] input_select_r;
  reg [7:0] active_sel_r;
  reg [7:0] active_sel_nxt;
  reg enable_r;
  reg busy_r;
  reg busy_nxt;
  reg start_pulse_r;
  reg start_pulse_nxt;
  reg done_flag_r;
  reg done_flag_nxt;
  reg irq_en_r;
  reg [2:0] prescale_r;
  reg ctrl_a_free_r;
  reg bipolar_r;
  reg [6:0] ctrl_b_rest_r;
  reg [9:0] result_r;
  reg irq_status_r;
  reg irq_status_nxt;
  reg [7:0] irq_mask_r;
  reg [31:0] prdata_r;
  reg [7:0] rd_byte;

  wire sel_wr;
  wire ca_wr;
  wire cb_wr;
  wire mask_wr;
  wire status_rd;
  wire en_nxt;
  wire start_req;
  wire finish;
  wire [9:0] formatted;

  assign sel_wr = wr_acc & lane0 & (idx == `IDX_INPUT_SELECT);
  assign ca_wr = wr_acc & lane0 & (idx == `IDX_CTRL_A);
  assign cb_wr = wr_acc & lane0 & (idx == `IDX_CTRL_B);
  assign mask_wr = wr_acc & lane0 & (idx == `IDX_IRQ_MASK);
  assign status_rd = rd_acc & (idx == `IDX_IRQ_STATUS);
  assign en_nxt = ca_wr ? pwdata[`CA_ENABLE] : enable_r;
  // start written with enable in the same write is accepted
  assign start_req = ca_wr & pwdata[`CA_START] & pwdata[`CA_ENABLE] & ~busy_r;
  // completion is only honoured for a conversion this block started
  assign finish = busy_r & conv_done & enable_r;

  // ----------------------------------------
  // software written registers
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_select_r <= `RST_INPUT_SELECT;
      enable_r <= 1'b0;
      irq_en_r <= 1'b0;
      prescale_r <= 3'h0;
      ctrl_a_free_r <= 1'b0;
      bipolar_r <= 1'b0;
      ctrl_b_rest_r <= 7'h00;
      irq_mask_r <= `RST_IRQ_MASK;
    end else begin
      if (sel_wr) begin
        input_select_r <= pwdata[7:0];
      end
      if (ca_wr) begin
        enable_r <= pwdata[`CA_ENABLE];
        ctrl_a_free_r <= pwdata[5];
        irq_en_r <= pwdata[`CA_IRQ_EN];
        prescale_r <= pwdata[2:0];
      end
      if (cb_wr) begin
        bipolar_r <= pwdata[`CB_BIPOLAR];
        ctrl_b_rest_r <= pwdata[6:0];
      end
      if (mask_wr) begin
        irq_mask_r <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------
  // conversion sequencing and selection lock
  // ----------------------------------------
  always @* begin
    busy_nxt = busy_r;
    start_pulse_nxt = 1'b0;
    active_sel_nxt = active_sel_r;
    if (!en_nxt) begin
      // disabling ends a conversion in progress
      busy_nxt = 1'b0;
    end else if (start_req) begin
      busy_nxt = 1'b1;
      start_pulse_nxt = 1'b1;
    end else if (finish) begin
      busy_nxt = 1'b0;
    end
    // a select written on the finishing edge serves the next conversion
    // selection locked while busy
    if (!busy_r || finish) begin
      active_sel_nxt = sel_wr ? pwdata[7:0] : input_select_r;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_r <= 1'b0;
      start_pulse_r <= 1'b0;
      active_sel_r <= `RST_INPUT_SELECT;
    end else begin
      busy_r <= busy_nxt;
      start_pulse_r <= start_pulse_nxt;
      active_sel_r <= active_sel_nxt;
    end
  end

  // ----------------------------------------
  // result capture and completion flag
  // ----------------------------------------
  always @* begin
    done_flag_nxt = done_flag_r;
    // write one or vector acknowledge clears
    if ((ca_wr & pwdata[`CA_DONE_FLAG]) | irq_ack) begin
      done_flag_nxt = 1'b0;
    end
    // set wins over a clear in the same cycle
    if (finish) begin
      done_flag_nxt = 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_flag_r <= 1'b0;
      result_r <= 10'h000;
    end else begin
      done_flag_r <= done_flag_nxt;
      // results change only with the flag
      if (finish) begin
        result_r <= formatted;
      end
    end
  end

  // ----------------------------------------
  // interrupt status
  // ----------------------------------------
  always @* begin
    irq_status_nxt = irq_status_r;
    if (status_rd) begin
      irq_status_nxt = 1'b0;
    end
    // a completion beside the clearing read still wins
    if (finish) begin
      irq_status_nxt = 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_r <= 1'b0;
    end else begin
      irq_status_r <= irq_status_nxt;
    end
  end

  // control a interrupt enable still gates the line for software using that bit
  assign irq = irq_status_r & irq_mask_r[`IRQ_DONE] & irq_en_r;

  // ----------------------------------------
  // read data
  // ----------------------------------------
  always @* begin
    rd_byte = 8'h00;
    case (idx)
      `IDX_CTRL_B: begin
        rd_byte = {bipolar_r, ctrl_b_rest_r};
      end
      `IDX_RESULT_LOW: begin
        rd_byte = result_r[7:0];
      end
      `IDX_RESULT_HIGH: begin
        rd_byte = {6'h00, result_r[9:8]};
      end
      `IDX_CTRL_A: begin
        rd_byte = {enable_r, busy_r, ctrl_a_free_r, done_flag_r, irq_en_r, prescale_r};
      end
      `IDX_INPUT_SELECT: begin
        rd_byte = input_select_r;
      end
      `IDX_IRQ_STATUS: begin
        rd_byte = {7'h00, irq_status_r};
      end
      `IDX_IRQ_MASK: begin
        rd_byte = irq_mask_r;
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  // read data is captured in setup so it comes from a flip-flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
    end else if (setup_ph & ~pwrite) begin
      prdata_r <= (upper_zero && is_reg(idx)) ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end

  assign prdata = prdata_r;

  // ----------------------------------------
  // analog control
  // ----------------------------------------
  adc_sel_decode u_decode (
    .sel(active_sel_r),
    .diff_mode(diff_mode),
    .gain_20x(gain_20x),
    .temp_sensor_en(temp_sensor_en),
    .ref_vcc_en(ref_vcc_en),
    .ref_ext_en(ref_ext_en),
    .ref_int_en(ref_int_en),
    .ref_pin_drive(ref_pin_drive)
  );

  // bipolar is read live; software changes it between conversions only
  adc_result_format u_format (
    .se_code(conv_se_code),
    .diff_code(conv_diff_code),
    .diff_mode(diff_mode),
    .gain_20x(gain_20x),
    .bipolar(bipolar_r),
    .result(formatted)
  );

  assign conv_start = start_pulse_r;
  assign conv_busy = busy_r;
  assign adc_enable = enable_r;
  // the analog mux sees the locked copy, not the software register
  assign active_channel = active_sel_r[`SEL_CHAN_HI:`SEL_CHAN_LO];
  assign bipolar_mode = bipolar_r;

endmodule
`default_nettype wire

// *** src/adc_sel_consts.vh ***
// register offsets, field positions and reset values of the result and selection block
`ifndef ADC_SEL_CONSTS_VH
`define ADC_SEL_CONSTS_VH

// ----------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------
`define IDX_CTRL_B 4'h3
`define IDX_RESULT_LOW 4'h4
`define IDX_RESULT_HIGH 4'h5
`define IDX_CTRL_A 4'h6
`define IDX_INPUT_SELECT 4'h7
`define IDX_IRQ_STATUS 4'h8
`define IDX_IRQ_MASK 4'h9

// ----------------------------------------
// input select fields
// ----------------------------------------
`define SEL_REF_HI 7
`define SEL_REF_LO 6
`define SEL_CHAN_HI 5
`define SEL_CHAN_LO 0
`define SEL_GAIN_BIT 0
`define RST_INPUT_SELECT 8'h00

// ----------------------------------------
// control a and b fields
// ----------------------------------------
`define CA_ENABLE 7
`define CA_START 6
`define CA_DONE_FLAG 4
`define CA_IRQ_EN 3
`define CB_BIPOLAR 7
`define RST_CTRL_A 8'h00
`define RST_CTRL_B 8'h00

// ----------------------------------------
// interrupt status and mask
// ----------------------------------------
`define IRQ_DONE 0
`define RST_IRQ_MASK 8'h00

// ----------------------------------------
// codes
// ----------------------------------------
`define CHAN_TEMPERATURE 6'h22
`define CHAN_DIFF_FIRST 6'h08
`define CHAN_DIFF_LAST 6'h1f
`define CHAN_CAL_FIRST 6'h23
`define CHAN_CAL_LAST 6'h27
`define CHAN_REV_FIRST 6'h28
`define REF_SUPPLY 2'h0
`define REF_EXTERNAL 2'h1
`define REF_INTERNAL 2'h2
`define REF_INT_TO_PIN 2'h3
`define GAIN_HIGH 5'h14
`define GAIN_UNITY 5'h01
`define UNI_MAX 16'h03ff
`define BIP_MAX 16'h01ff
`define BIP_MIN 16'hfe00

`endif

// *** src/adc_sel_decode.v ***
// decode of the locked channel and reference codes into analog controls
`timescale 1ns/1ps
`default_nettype none
`include "adc_sel_consts.vh"

module adc_sel_decode (
  input wire [7:0] sel,
  output reg diff_mode,
  output reg gain_20x,
  output reg temp_sensor_en,
  output reg ref_vcc_en,
  output reg ref_ext_en,
  output reg ref_int_en,
  output reg ref_pin_drive
);
  wire [5:0] chan;
  wire [1:0] ref_code;
  assign chan = sel[`SEL_CHAN_HI:`SEL_CHAN_LO];
  assign ref_code = sel[`SEL_REF_HI:`SEL_REF_LO];

  always @* begin
    diff_mode = ((chan >= `CHAN_DIFF_FIRST) && (chan <= `CHAN_DIFF_LAST)) ||
                ((chan >= `CHAN_CAL_FIRST) && (chan <= `CHAN_CAL_LAST)) ||
                (chan >= `CHAN_REV_FIRST);
    gain_20x = diff_mode & chan[`SEL_GAIN_BIT];
    temp_sensor_en = (chan == `CHAN_TEMPERATURE);
    ref_vcc_en = (ref_code == `REF_SUPPLY);
    ref_ext_en = (ref_code == `REF_EXTERNAL);
    ref_int_en = (ref_code == `REF_INTERNAL) || (ref_code == `REF_INT_TO_PIN);
    ref_pin_drive = (ref_code == `REF_INT_TO_PIN);
  end
endmodule
`default_nettype wire

// *** src/adc_result_format.v ***
// scaling and saturation of raw converter codes into the ten-bit result
`timescale 1ns/1ps
`default_nettype none
`include "adc_sel_consts.vh"

module adc_result_format (
  input wire [9:0] se_code,
  input wire signed [10:0] diff_code,
  input wire diff_mode,
  input wire gain_20x,
  input wire bipolar,
  output reg [9:0] result
);
  wire signed [15:0] product;
  wire signed [15:0] halved;
  assign product = $signed({{5{diff_code[10]}}, diff_code}) *
                   $signed({11'h000, (gain_20x ? `GAIN_HIGH : `GAIN_UNITY)});
  assign halved = product >>> 1;

  function [9:0] clamp;
    input signed [15:0] v;
    input signed [15:0] lo;
    input signed [15:0] hi;
    begin
      if (v < lo) begin
        clamp = lo[9:0];
      end else if (v > hi) begin
        clamp = hi[9:0];
      end else begin
        clamp = v[9:0];
      end
    end
  endfunction

  always @* begin
    if (!diff_mode) begin
      result = se_code;
    end else if (bipolar) begin
      result = clamp(halved, $signed(`BIP_MIN), $signed(`BIP_MAX));
    end else begin
      result = clamp(product, 16'sh0000, $signed(`UNI_MAX));
    end
  end
endmodule
`default_nettype wire

// *** dv/adc_result_and_reference_select_assertions.sv ***
// port assertions of the converter result and selection block
`timescale 1ns/1ps
`default_nettype none
module adc_sel_checker (
  input wire pclk,
  input wire presetn,
  input wire conv_done,
  input wire conv_busy,
  input wire adc_enable,
  input wire [5:0] active_channel,
  input wire diff_mode,
  input wire gain_20x,
  input wire bipolar_mode,
  input wire temp_sensor_en,
  input wire ref_vcc_en,
  input wire ref_ext_en,
  input wire ref_int_en,
  input wire ref_pin_drive
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----
  // sequences
  // ----
  sequence finish_s;
    conv_done && conv_busy && adc_enable;
  endsequence
  sequence locked_s;
    conv_busy ##1 conv_busy;
  endsequence
  sel_lock_a: assert property (
    locked_s |-> $stable({ref_vcc_en, ref_ext_en, ref_int_en, ref_pin_drive, active_channel}))
    else $error("selection moved during conversion");
  done_end_a: assert property (finish_s |=> !conv_busy)
    else $error("busy after completion");
  temp_sens_a: assert property (temp_sensor_en == (active_channel == 6'h22))
    else $error("temperature enable wrong");
  ref_code_a: assert property ($onehot({ref_vcc_en, ref_ext_en, ref_int_en}))
    else $error("reference decode not one hot");
  pin_drive_a: assert property (ref_pin_drive |-> ref_int_en && !ref_ext_en)
    else $error("pin driven without internal reference");
  gain_sel_a: assert property (gain_20x == (diff_mode && active_channel[0]))
    else $error("gain select wrong");
  diff_dec_a: assert property (
    diff_mode == (active_channel inside {[6'h08:6'h1f], [6'h23:6'h3f]}))
    else $error("differential decode wrong");
  reset_uni_a: assert property ($rose(presetn) |-> !bipolar_mode)
    else $error("bipolar after reset");
endmodule
bind adc_result_and_reference_select adc_sel_checker chk (.pclk(pclk), .presetn(presetn),
  .conv_done(conv_done), .conv_busy(conv_busy), .adc_enable(adc_enable),
  .active_channel(active_channel), .diff_mode(diff_mode), .gain_20x(gain_20x),
  .bipolar_mode(bipolar_mode), .temp_sensor_en(temp_sensor_en), .ref_vcc_en(ref_vcc_en),
  .ref_ext_en(ref_ext_en), .ref_int_en(ref_int_en), .ref_pin_drive(ref_pin_drive));
`default_nettype wire

// *** dv/analog_front_model.sv ***
// behavioural converter core and analog inputs
`timescale 1ns/1ps
`default_nettype none
module analog_front_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [7:0] lat,
  input wire logic [9:0] se_val,
  input wire logic [10:0] diff_val,
  output logic done,
  output logic [9:0] se_code,
  output logic [10:0] diff_code
);
  logic [7:0] cnt;
  // no voltage applied on the reference pin
  // codes toggle outside the done cycle so a stale capture shows
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 8'h00;
      done <= 1'b0;
      se_code <= 10'h000;
      diff_code <= 11'h000;
    end else begin
      done <= cnt == 8'h01;
      cnt <= start ? lat : (cnt != 8'h00 ? cnt - 8'h01 : 8'h00);
      se_code <= cnt == 8'h01 ? se_val : ~se_code;
      diff_code <= cnt == 8'h01 ? diff_val : ~diff_code;
    end
  end
endmodule
`default_nettype wire

// *** dv/adc_result_and_reference_select_bench.sv ***
// self-checking bench of the converter result and selection block
`timescale 1ns/1ps
`default_nettype none
module adc_result_and_reference_select_bench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, irq_ack = 0, err;
  logic [7:0] paddr = 0;
  logic [7:0] lat_v = 8'h0c;
  logic [31:0] pwdata = 0, q;
  logic [9:0] se_v = 0;
  logic [10:0] diff_v = 0;
  wire [31:0] prdata;
  wire pready, pslverr, conv_done, conv_start, conv_busy, adc_enable, diff_mode, gain_20x;
  wire bipolar_mode, temp_sensor_en, ref_vcc_en, ref_ext_en, ref_int_en, ref_pin_drive, irq;
  wire [9:0] se_code;
  wire [10:0] diff_code;
  wire [5:0] active_channel;
  wire [3:0] refs = {ref_vcc_en, ref_ext_en, ref_int_en, ref_pin_drive};
  int n_mismatch = 0, n_compared = 0;
  int exp_q[$];
  always #20 pclk = ~pclk;
  adc_result_and_reference_select dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .conv_done(conv_done),
    .conv_se_code(se_code), .conv_diff_code(diff_code), .irq_ack(irq_ack),
    .conv_start(conv_start), .conv_busy(conv_busy), .adc_enable(adc_enable),
    .active_channel(active_channel), .diff_mode(diff_mode), .gain_20x(gain_20x),
    .bipolar_mode(bipolar_mode), .temp_sensor_en(temp_sensor_en), .ref_vcc_en(ref_vcc_en),
    .ref_ext_en(ref_ext_en), .ref_int_en(ref_int_en), .ref_pin_drive(ref_pin_drive), .irq(irq));
  analog_front_model pins (.clk(pclk), .rst_n(presetn), .start(conv_start), .lat(lat_v),
    .se_val(se_v), .diff_val(diff_v), .done(conv_done), .se_code(se_code), .diff_code(diff_code));
  task automatic end_of_test;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  function automatic logic [3:0] dec(input int r);
    return r == 0 ? 4'h8 : r == 1 ? 4'h4 : r == 2 ? 4'h2 : 4'h3;
  endfunction
  // expected ten-bit result from the raw codes
  function automatic int fmt(input int ch, input int bip, input int se, input int df);
    int v;
    if (!((ch >= 8 && ch <= 31) || ch >= 35)) return se;
    v = df * ((ch % 2) ? 20 : 1);
    if (bip == 0) return v < 0 ? 0 : (v > 1023 ? 1023 : v);
    v = v >>> 1;
    v = v < -512 ? -512 : (v > 511 ? 511 : v);
    return v & 1023;
  endfunction
  task automatic conv(input int i);
    int ch, r, n, bip, se, df, m, k;
    k = $urandom_range(0, 3);
    ch = k == 0 ? $urandom_range(0, 7) : k == 1 ? 34 : k == 2 ? $urandom_range(8, 31)
      : $urandom_range(35, 63);
    r = ch == 34 ? 2 : $urandom_range(0, 2);
    n = $urandom_range(0, 3);
    bip = $urandom_range(0, 1);
    se = $urandom_range(0, 1023);
    df = $urandom_range(0, 2047) - 1024;
    m = i < 20;
    se_v <= 10'(se);
    diff_v <= 11'(df);
    lat_v <= 8'($urandom_range(12, 40));
    wr(8'h24, 32'(m));
    wr(8'h0c, 32'(bip << 7));
    wr(8'h1c, 32'(r * 64 + ch));
    repeat (25) @(negedge pclk);
    chk(32'(temp_sensor_en), 32'(ch == 34));
    chk(32'(bipolar_mode), 32'(bip));
    exp_q.push_back(fmt(ch, bip, se, df));
    wr(8'h18, 32'hc8);
    @(negedge pclk);
    chk(32'({conv_start, conv_busy}), 32'h3);
    wr(8'h1c, 32'(n * 64 + ch));
    @(negedge pclk);
    chk(32'(refs), 32'(dec(r)));
    for (k = 0; k < 100 && conv_busy === 1'b1; k++) @(negedge pclk);
    chk(32'(conv_busy), 32'h0);
    chk(32'(refs), 32'(dec(n)));
    chk(32'(irq), 32'(m));
    rd(8'h10, exp_q[0] & 32'hff);
    rd(8'h14, exp_q.pop_front() >> 8);
    rd(8'h20, 32'h1);
    @(negedge pclk);
    chk(32'(irq), 32'h0);
    rd(8'h18, 32'h98);
    if (i % 2) wr(8'h18, 32'h98);
    else begin
      @(posedge pclk);
      irq_ack <= 1'b1;
      @(posedge pclk);
      irq_ack <= 1'b0;
    end
    rd(8'h18, 32'h88);
  endtask
  initial begin
    int i;
    void'($urandom(89818));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h0c, 32'h0);
    rd(8'h18, 32'h0);
    rd(8'h1c, 32'h0);
    rd(8'h40, 32'h0);
    chk(32'(err), 32'h1);
    for (i = 0; i < 4; i++) begin
      wr(8'h1c, 32'(i * 64 + 5));
      @(negedge pclk);
      chk(32'(refs), 32'(dec(i)));
      rd(8'h1c, 32'(i * 64 + 5));
    end
    for (i = 0; i < 24; i++) conv(i);
    // mid-run reset with bipolar set must come back unipolar
    wr(8'h0c, 32'h80);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk(32'(bipolar_mode), 32'h0);
    rd(8'h0c, 32'h0);
    rd(8'h18, 32'h0);
    rd(8'h1c, 32'h0);
    end_of_test;
  end
  // watchdog well beyond the expected few thousand cycles
  initial begin
    #400000;
    n_mismatch++;
    end_of_test;
  end
endmodule
`default_nettype wire
